// ===== pkg/tcs_pkg.sv
// Notes on behaviour
// - code 1f loads a trajectory: control word then zero to twelve data bytes
// - control word is two bytes, high byte first, and selects following data
// - bit 11 selects velocity mode; bit 12 forward, velocity mode only
// - bit 8 turns the motor off by driving the zero-drive offset-binary code; here drive_code is always 80 and bit 8 only sets the motor off flag
// - bit 9 stops abruptly by copying current position into target
// - bit 10 decelerates to a stop with the programmed acceleration
// - position mode moves always end with an automatic smooth stop
// - bits 5,3,1 flag accel, velocity, position data; bits 4,2,0 mark relative
// - each parameter is two words, msw and msb first, order accel, velocity, position
// - accel and velocity are unsigned, max 3ffffff, low 16 bits fractional
// - position is signed 32-bit, range fc000000 to 3ffffff
// - data sits in primary buffers until start motion copies it to working registers
// - start motion is code 01 with no data; launches last loaded trajectory
// - start during motion after acceleration change is ignored and flags command error
// - data reports: command code to command port, then read data port; not implemented, data_oe only with port select low
// - status byte read with chip select, port select and read strobe low, anytime
// - status bits 7..0: motor off, breakpoint, pos error, wrap, index, done, cmd err, busy
// - motor off set on reset, reset command, armed position error, or motor-off stop
// - motor-off stop sets flag at start motion; otherwise start motion clears it
// - breakpoint and position-error flags set when thresholds exceeded, mask independent
// - wraparound flag set on position overflow, mask independent
// - code 1d plus two bytes clears flags whose bit 1..6 in second byte is zero
// - writes while busy are ignored and raise no command error
package tcs_pkg;
  localparam logic [7:0] CMD_LOAD_TRAJ = 8'h1f;
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_CLR_INT = 8'h1d;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam int CW_FWD = 12;
  localparam int CW_VEL = 11;
  localparam int CW_SMOOTH = 10;
  localparam int CW_ABRUPT = 9;
  localparam int CW_OFF = 8;
  localparam int CW_ACC_LD = 5;
  localparam int CW_ACC_REL = 4;
  localparam int CW_VEL_LD = 3;
  localparam int CW_VEL_REL = 2;
  localparam int CW_POS_LD = 1;
  localparam int CW_POS_REL = 0;
  localparam int ST_MOTOR_OFF = 7;
  localparam int ST_BREAK = 6;
  localparam int ST_POS_ERR = 5;
  localparam int ST_WRAP = 4;
  localparam int ST_INDEX = 3;
  localparam int ST_DONE = 2;
  localparam int ST_CMD_ERR = 1;
  localparam int ST_BUSY = 0;
  localparam logic [31:0] ACC_VEL_MAX = 32'h03ffffff;
  localparam logic [31:0] POS_MIN = 32'hfc000000;
  localparam logic [31:0] POS_MAX = 32'h03ffffff;
  localparam logic [7:0] DRIVE_ZERO = 8'h80;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [2:0] BUSY_CYCLES = 3'd3;
  typedef enum logic [4:0] {
    TCS_IDLE = 5'b00001,
    TCS_CW_HI = 5'b00010,
    TCS_CW_LO = 5'b00100,
    TCS_DATA = 5'b01000,
    TCS_CLR = 5'b10000
  } tcs_state_t;
endpackage

// ===== hw/tcs_sync.sv
`timescale 1ns/1ps
// ************
// two-flop synchroniser
// ************
module tcs_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic d, // async level
  output logic q // synced level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } tcs_sync_t;
  tcs_sync_t r, next_r;
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= {INIT, INIT};
    end else begin
      r <= next_r;
    end
  end
  assign q = r.s2;
endmodule

// ===== hw/tcs_param.sv
`timescale 1ns/1ps
// ************
// one trajectory parameter: working value updated at start
// ************
module tcs_param #(
  parameter logic [31:0] MIN_VAL = 32'h0,
  parameter logic [31:0] MAX_VAL = 32'h0,
  parameter logic SIGNED_VAL = 1'b0
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic load, // start transfer pulse
  input wire logic present, // buffered value pending
  input wire logic relative, // add rather than replace
  input wire logic [31:0] buf_val, // primary buffer
  output logic [31:0] work // working register
);
  typedef struct packed {
    logic [31:0] work;
  } tcs_param_t;
  tcs_param_t r, next_r;
  logic [31:0] sum;
  logic [31:0] clipped;
  always_comb begin
    sum = relative ? 32'(r.work + buf_val) : buf_val;
    clipped = sum;
    if (SIGNED_VAL) begin
      if ($signed(sum) > $signed(MAX_VAL)) clipped = MAX_VAL;
      if ($signed(sum) < $signed(MIN_VAL)) clipped = MIN_VAL;
    end else if (sum > MAX_VAL) begin
      clipped = MAX_VAL;
    end
    next_r.work = (load && present) ? clipped : r.work;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign work = r.work;
endmodule

// ===== hw/tcs_top.sv
`timescale 1ns/1ps
// ************
// trajectory command path and status byte
// ************
module tcs_top
  import tcs_pkg::*;
(
  input wire logic clk_sys, // 250 mhz clock
  input wire logic rst, // async reset, high
  input wire logic chip_select_n, // host chip select
  input wire logic port_select_n, // low: command/status, high: data
  input wire logic read_n, // host read strobe
  input wire logic write_n, // host write strobe
  input wire logic [7:0] data_in, // host data bus in
  output logic [7:0] data_out, // host data bus out
  output logic data_oe, // drive data bus
  input wire logic [31:0] actual_pos, // current position from loop
  input wire logic move_done, // profile generator finished
  input wire logic breakpoint_hit, // breakpoint exceeded event
  input wire logic pos_err_hit, // error threshold exceeded event
  input wire logic err_stop_armed, // stop-on-error armed
  input wire logic wrap_hit, // position overflow event
  input wire logic index_hit, // index captured event
  output logic [31:0] acc_work, // working acceleration
  output logic [31:0] vel_work, // working velocity
  output logic [31:0] pos_target, // working target position
  output logic velocity_mode, // 1 velocity, 0 position mode
  output logic forward_dir, // forward in velocity mode
  output logic smooth_stop, // decelerate to stop, level
  output logic start_pulse, // start executed, one cycle
  output logic [7:0] drive_code, // motor output code
  output logic [7:0] status_flags // status byte
);
  typedef struct packed {
    tcs_state_t st;
    logic [15:0] cw_buf;
    logic [15:0] cw_work;
    logic [31:0] acc_buf;
    logic [31:0] vel_buf;
    logic [31:0] pos_buf;
    logic acc_pend;
    logic vel_pend;
    logic pos_pend;
    logic acc_changed;
    logic moving;
    logic [31:0] shift;
    logic [1:0] sel;
    logic [1:0] nbyte;
    logic [2:0] busy_cnt;
    logic [7:0] flags;
    logic smooth;
    logic vmode;
    logic fwd;
    logic start;
    logic abrupt;
    logic [7:0] dout;
    logic [31:0] hold_pos;
    logic wr_d;
  } tcs_reg_t;
  tcs_reg_t r, next_r;
  logic cs_s, ps_s, rd_s, wr_s;
  logic wr_edge, rd_active;
  logic [31:0] pos_work;
  logic [1:0] nxt_sel;
  logic [15:0] cw;
  // ************
  // pin synchronisers
  // ************
  tcs_sync #(.INIT(1'b1)) u_cs (.clk_sys(clk_sys), .rst(rst), .d(chip_select_n), .q(cs_s));
  tcs_sync #(.INIT(1'b1)) u_ps (.clk_sys(clk_sys), .rst(rst), .d(port_select_n), .q(ps_s));
  tcs_sync #(.INIT(1'b1)) u_rd (.clk_sys(clk_sys), .rst(rst), .d(read_n), .q(rd_s));
  tcs_sync #(.INIT(1'b1)) u_wr (.clk_sys(clk_sys), .rst(rst), .d(write_n), .q(wr_s));
  // data bus is sampled at the write edge; host holds it stable across the strobe
  // ************
  // working registers
  // ************
  tcs_param #(.MIN_VAL(32'h0), .MAX_VAL(ACC_VEL_MAX), .SIGNED_VAL(1'b0)) u_acc (
    .clk_sys(clk_sys), .rst(rst), .load(next_r.start), .present(r.acc_pend),
    .relative(r.cw_buf[CW_ACC_REL]), .buf_val(r.acc_buf), .work(acc_work)
  );
  tcs_param #(.MIN_VAL(32'h0), .MAX_VAL(ACC_VEL_MAX), .SIGNED_VAL(1'b0)) u_vel (
    .clk_sys(clk_sys), .rst(rst), .load(next_r.start), .present(r.vel_pend),
    .relative(r.cw_buf[CW_VEL_REL]), .buf_val(r.vel_buf), .work(vel_work)
  );
  tcs_param #(.MIN_VAL(POS_MIN), .MAX_VAL(POS_MAX), .SIGNED_VAL(1'b1)) u_pos (
    .clk_sys(clk_sys), .rst(rst), .load(next_r.start), .present(r.pos_pend),
    .relative(r.cw_buf[CW_POS_REL]), .buf_val(r.pos_buf), .work(pos_work)
  );
  // next parameter after sel, in order accel(3), velocity(2), position(1), none(0)
  function automatic logic [1:0] pick(input logic [15:0] w, input logic [1:0] after);
    logic [1:0] res;
    res = 2'd0;
    if (after > 2'd3 - 2'd0 && w[CW_ACC_LD]) res = 2'd3;
    else if (after > 2'd2 && w[CW_VEL_LD]) res = 2'd2;
    else if (after > 2'd1 && w[CW_POS_LD]) res = 2'd1;
    else if (after > 2'd2 && w[CW_POS_LD]) res = 2'd1;
    return res;
  endfunction
  always_comb begin
    wr_edge = !cs_s && !wr_s && r.wr_d;
    rd_active = !cs_s && !rd_s;
    cw = r.cw_buf;
    nxt_sel = 2'd0;
    next_r = r;
    next_r.wr_d = !(!cs_s && !wr_s);
    next_r.start = 1'b0;
    next_r.busy_cnt = (r.busy_cnt != 3'd0) ? r.busy_cnt - 3'd1 : 3'd0;
    // ************
    // status events; set wins over clear
    // ************
    if (move_done && r.moving) begin
      next_r.moving = 1'b0;
      next_r.acc_changed = 1'b0;
      next_r.smooth = 1'b0;
    end
    // ************
    // host writes, ignored while busy
    // ************
    if (wr_edge && r.busy_cnt == 3'd0) begin
      next_r.busy_cnt = BUSY_CYCLES;
      if (!ps_s) begin
        next_r.st = TCS_IDLE;
        case (data_in)
          CMD_LOAD_TRAJ: begin
            next_r.st = TCS_CW_HI;
          end
          CMD_CLR_INT: begin
            next_r.st = TCS_CLR;
            next_r.nbyte = 2'd0;
          end
          CMD_RESET: begin
            next_r.flags[ST_MOTOR_OFF] = 1'b1;
            next_r.moving = 1'b0;
          end
          CMD_START: begin
            if (r.moving && r.acc_changed) begin
              next_r.flags[ST_CMD_ERR] = 1'b1;
            end else begin
              next_r.start = 1'b1;
              next_r.cw_work = cw;
              next_r.acc_pend = 1'b0;
              next_r.vel_pend = 1'b0;
              next_r.pos_pend = 1'b0;
              next_r.acc_changed = 1'b0;
              next_r.vmode = cw[CW_VEL];
              next_r.fwd = cw[CW_VEL] & cw[CW_FWD];
              next_r.flags[ST_MOTOR_OFF] = cw[CW_OFF];
              next_r.abrupt = cw[CW_ABRUPT];
              next_r.hold_pos = actual_pos;
              next_r.smooth = cw[CW_SMOOTH];
              next_r.moving = !cw[CW_OFF] && !cw[CW_ABRUPT];
              next_r.flags[ST_DONE] = 1'b0;
              next_r.cw_buf[CW_ABRUPT:CW_OFF] = 2'b00;
              next_r.cw_buf[CW_SMOOTH] = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (r.st)
          TCS_CW_HI: begin
            next_r.cw_buf[15:8] = data_in;
            next_r.st = TCS_CW_LO;
          end
          TCS_CW_LO: begin
            cw = {r.cw_buf[15:8], data_in};
            next_r.cw_buf = cw;
            nxt_sel = pick(cw, 2'd3 + 2'd0 == 2'd3 ? 2'd3 : 2'd3);
            if (cw[CW_ACC_LD]) nxt_sel = 2'd3;
            else if (cw[CW_VEL_LD]) nxt_sel = 2'd2;
            else if (cw[CW_POS_LD]) nxt_sel = 2'd1;
            next_r.sel = nxt_sel;
            next_r.nbyte = 2'd0;
            next_r.st = (nxt_sel != 2'd0) ? TCS_DATA : TCS_IDLE;
          end
          TCS_DATA: begin
            next_r.shift = {r.shift[23:0], data_in};
            next_r.nbyte = r.nbyte + 2'd1;
            if (r.nbyte == 2'd3) begin
              case (r.sel)
                2'd3: begin
                  next_r.acc_buf = {r.shift[23:0], data_in};
                  next_r.acc_pend = 1'b1;
                  next_r.acc_changed = 1'b1;
                end
                2'd2: begin
                  next_r.vel_buf = {r.shift[23:0], data_in};
                  next_r.vel_pend = 1'b1;
                end
                default: begin
                  next_r.pos_buf = {r.shift[23:0], data_in};
                  next_r.pos_pend = 1'b1;
                end
              endcase
              if (r.sel == 2'd3 && r.cw_buf[CW_VEL_LD]) nxt_sel = 2'd2;
              else if (r.sel >= 2'd2 && r.cw_buf[CW_POS_LD]) nxt_sel = 2'd1;
              else nxt_sel = 2'd0;
              next_r.sel = nxt_sel;
              next_r.st = (nxt_sel != 2'd0) ? TCS_DATA : TCS_IDLE;
            end
          end
          TCS_CLR: begin
            next_r.nbyte = r.nbyte + 2'd1;
            if (r.nbyte == 2'd1) begin
              next_r.flags[6:1] = r.flags[6:1] & data_in[6:1];
              next_r.st = TCS_IDLE;
            end
          end
          default: begin
            next_r.st = TCS_IDLE;
          end
        endcase
      end
    end
    // hardware events applied last so a set beats a simultaneous clear
    if (breakpoint_hit) next_r.flags[ST_BREAK] = 1'b1;
    if (pos_err_hit) begin
      next_r.flags[ST_POS_ERR] = 1'b1;
      if (err_stop_armed) next_r.flags[ST_MOTOR_OFF] = 1'b1;
    end
    if (wrap_hit) next_r.flags[ST_WRAP] = 1'b1;
    if (index_hit) next_r.flags[ST_INDEX] = 1'b1;
    if (move_done && r.moving) next_r.flags[ST_DONE] = 1'b1;
    next_r.flags[ST_BUSY] = (next_r.busy_cnt != 3'd0);
    // ************
    // read path: status byte on port select low
    // ************
    // copied every cycle so the byte is settled before the synced strobe opens the bus
    next_r.dout = r.flags;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.st <= TCS_IDLE;
      r.flags <= STATUS_RESET;
      r.wr_d <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
  // abrupt stop: target is the position captured when start executed
  assign pos_target = r.abrupt ? r.hold_pos : pos_work;
  assign velocity_mode = r.vmode;
  assign forward_dir = r.fwd;
  assign smooth_stop = r.smooth;
  assign start_pulse = r.start;
  assign drive_code = DRIVE_ZERO;
  assign status_flags = r.flags;
  assign data_out = r.dout;
  assign data_oe = rd_active && !ps_s;
endmodule

// ===== testbench/tcs_properties.sv
`timescale 1ns/1ps
// ************
// checker on the top ports
// ************
module tcs_properties
  import tcs_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic chip_select_n, // chip select
  input wire logic port_select_n, // port select
  input wire logic read_n, // read strobe
  input wire logic write_n, // write strobe
  input wire logic [7:0] data_in, // host bus in
  input wire logic [7:0] data_out, // host bus out
  input wire logic data_oe, // bus drive
  input wire logic [31:0] actual_pos, // current position
  input wire logic move_done, // move finished
  input wire logic breakpoint_hit, // breakpoint event
  input wire logic pos_err_hit, // error event
  input wire logic err_stop_armed, // stop on error
  input wire logic wrap_hit, // wrap event
  input wire logic index_hit, // index event
  input wire logic [31:0] acc_work, // working acceleration
  input wire logic [31:0] vel_work, // working velocity
  input wire logic [31:0] pos_target, // working target
  input wire logic velocity_mode, // mode
  input wire logic forward_dir, // direction
  input wire logic smooth_stop, // smooth stop
  input wire logic start_pulse, // start executed
  input wire logic [7:0] drive_code, // motor code
  input wire logic [7:0] status_flags // status byte
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_start_once; start_pulse |=> !start_pulse; endproperty
  a_start_once: assert property (p_start_once) else $error("start pulse too long");
  property p_busy_len; $rose(status_flags[ST_BUSY]) |-> status_flags[ST_BUSY] [*3] ##1 !status_flags[ST_BUSY]; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_drive_zero; drive_code == DRIVE_ZERO; endproperty
  a_drive_zero: assert property (p_drive_zero) else $error("drive code not zero drive");
  property p_break; breakpoint_hit |=> status_flags[ST_BREAK]; endproperty
  a_break: assert property (p_break) else $error("breakpoint flag missing");
  property p_perr; pos_err_hit |=> status_flags[ST_POS_ERR]; endproperty
  a_perr: assert property (p_perr) else $error("position error flag missing");
  property p_wrap; wrap_hit |=> status_flags[ST_WRAP]; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missing");
  property p_index; index_hit |=> status_flags[ST_INDEX]; endproperty
  a_index: assert property (p_index) else $error("index flag missing");
  property p_err_stop; pos_err_hit && err_stop_armed |=> status_flags[ST_MOTOR_OFF]; endproperty
  a_err_stop: assert property (p_err_stop) else $error("motor off not set on error");
  property p_work_at_start; $changed(acc_work) || $changed(vel_work) |-> start_pulse; endproperty
  a_work_at_start: assert property (p_work_at_start) else $error("working value moved without start");
  property p_status_read; data_oe && $stable(status_flags) |-> data_out == status_flags; endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");
  c_start: cover property (start_pulse);
  c_cmd_err: cover property ($rose(status_flags[ST_CMD_ERR]));
  c_read: cover property (data_oe);
endmodule

bind tcs_top tcs_properties u_props (.clk_sys, .rst, .chip_select_n, .port_select_n, .read_n, .write_n,
  .data_in, .data_out, .data_oe, .actual_pos, .move_done, .breakpoint_hit, .pos_err_hit, .err_stop_armed,
  .wrap_hit, .index_hit, .acc_work, .vel_work, .pos_target, .velocity_mode, .forward_dir, .smooth_stop,
  .start_pulse, .drive_code, .status_flags);

// ===== testbench/tcs_host.sv
`timescale 1ns/1ps
// ************
// host processor on the parallel port
// ************
module tcs_host (
  input wire logic clk_sys, // clock
  output logic chip_select_n = 1'b1, // chip select
  output logic port_select_n = 1'b1, // low command, high data
  output logic read_n = 1'b1, // read strobe
  output logic write_n = 1'b1, // write strobe
  output logic [7:0] data_in = 8'h00, // bus toward device
  input wire logic [7:0] data_out, // bus from device
  input wire logic data_oe // device drives bus
);
  task automatic read_status(output logic [7:0] st);
    @(posedge clk_sys);
    chip_select_n <= 1'b0;
    port_select_n <= 1'b0;
    read_n <= 1'b0;
    for (int n = 0; n < 20 && data_oe !== 1'b1; n++) @(negedge clk_sys);
    @(negedge clk_sys);
    st = data_out;
    @(posedge clk_sys);
    chip_select_n <= 1'b1;
    read_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic write_byte(input logic to_cmd, input logic [7:0] b);
    logic [7:0] st;
    @(posedge clk_sys);
    chip_select_n <= 1'b0;
    port_select_n <= !to_cmd;
    data_in <= b;
    write_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chip_select_n <= 1'b1;
    write_n <= 1'b1;
    data_in <= ~b; // released bus no longer shows the byte
    repeat (2) @(posedge clk_sys);
    st = 8'h01;
    for (int n = 0; n < 20 && st[0] !== 1'b0; n++) read_status(st);
    @(negedge clk_sys);
  endtask
endmodule

// ===== testbench/trajectory_command_status_tb_top.sv
`timescale 1ns/1ps
// ************
// testbench top
// ************
module trajectory_command_status_tb_top;
  import tcs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic chip_select_n, port_select_n, read_n, write_n, data_oe, err_stop_armed = 1'b0;
  logic velocity_mode, forward_dir, smooth_stop, start_pulse;
  logic [7:0] data_in, data_out, drive_code, status_flags, st;
  logic [31:0] actual_pos = 32'h0, acc_work, vel_work, pos_target, a, v, p;
  logic [31:0] ea = 32'h0, ev = 32'h0, ep = 32'h0;
  logic [15:0] cw;
  logic [4:0] evt = 5'h0; // move done, breakpoint, pos error, wrap, index
  int n_errors = 0;
  int comparisons = 0;
  always #2 clk_sys = ~clk_sys;
  tcs_host u_host (.clk_sys, .chip_select_n, .port_select_n, .read_n, .write_n, .data_in, .data_out, .data_oe);
  tcs_top DUT (.clk_sys, .rst, .chip_select_n, .port_select_n, .read_n, .write_n, .data_in, .data_out, .data_oe,
    .actual_pos, .move_done(evt[0]), .breakpoint_hit(evt[1]), .pos_err_hit(evt[2]), .err_stop_armed,
    .wrap_hit(evt[3]), .index_hit(evt[4]), .acc_work, .vel_work, .pos_target, .velocity_mode, .forward_dir,
    .smooth_stop, .start_pulse, .drive_code, .status_flags);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] upd(input logic ld, input logic rel, input logic [31:0] cur, input logic [31:0] val);
    return !ld ? cur : (rel ? cur + val : val);
  endfunction
  task automatic load_traj(input logic [15:0] w, input logic [31:0] ac, input logic [31:0] ve, input logic [31:0] po);
    logic [31:0] prm [3];
    prm = '{ac, ve, po};
    u_host.write_byte(1'b1, CMD_LOAD_TRAJ);
    u_host.write_byte(1'b0, w[15:8]);
    u_host.write_byte(1'b0, w[7:0]);
    for (int i = 0; i < 3; i++) begin
      if (w[5 - 2 * i]) begin
        for (int j = 3; j >= 0; j--) u_host.write_byte(1'b0, prm[i][8 * j +: 8]);
      end
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys);
    evt <= 5'(1 << k);
    @(posedge clk_sys);
    evt <= 5'h0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic clear_flags(input logic [7:0] m);
    u_host.write_byte(1'b1, CMD_CLR_INT);
    u_host.write_byte(1'b0, 8'h00);
    u_host.write_byte(1'b0, m);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    void'($urandom(32'h8bd12c95));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check(32'(status_flags), 32'(STATUS_RESET));
    check(32'(drive_code), 32'(DRIVE_ZERO));
    check(acc_work | vel_work | pos_target, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = ($urandom & 32'h003fffff) + 32'h1;
      a = v >> 1;
      p = ($urandom & 32'h003fffff) - 32'h00200000;
      cw = (i == 0) ? 16'h002a : 16'($urandom & 32'h183f);
      load_traj(cw, a, v, p);
      check(acc_work, ea);
      u_host.write_byte(1'b1, CMD_START);
      ea = upd(cw[CW_ACC_LD], cw[CW_ACC_REL], ea, a);
      ev = upd(cw[CW_VEL_LD], cw[CW_VEL_REL], ev, v);
      ep = upd(cw[CW_POS_LD], cw[CW_POS_REL], ep, p);
      check(acc_work, ea);
      check(vel_work, ev);
      check(pos_target, ep);
      check(32'(velocity_mode), 32'(cw[CW_VEL]));
      if (cw[CW_VEL]) check(32'(forward_dir), 32'(cw[CW_FWD]));
      check(32'(status_flags[ST_MOTOR_OFF]), 32'h0);
      pulse(0);
      if (!cw[CW_VEL]) check(32'(status_flags[ST_DONE]), 32'h1);
      clear_flags(8'h00);
      check(32'(status_flags[6:1]), 32'h0);
    end
    $display("test random trajectories done");
    for (int k = CW_OFF; k <= CW_SMOOTH; k++) begin
      @(posedge clk_sys);
      actual_pos <= $urandom & 32'h003fffff;
      load_traj(16'(1 << k), a, v, p);
      check(32'(status_flags[ST_MOTOR_OFF]), 32'(k == CW_ABRUPT));
      u_host.write_byte(1'b1, CMD_START);
      if (k == CW_OFF) check(32'(status_flags[ST_MOTOR_OFF]), 32'h1);
      if (k == CW_ABRUPT) check(pos_target, actual_pos);
      if (k == CW_SMOOTH) check(32'(smooth_stop), 32'h1);
      pulse(0);
    end
    $display("test manual stops done");
    a = 32'h00000100;
    load_traj(16'h0020, a, v, p);
    u_host.write_byte(1'b1, CMD_START);
    load_traj(16'h0020, a + 32'h1, v, p);
    u_host.write_byte(1'b1, CMD_START);
    check(acc_work, a);
    check(32'(status_flags[ST_CMD_ERR]), 32'h1);
    pulse(0);
    clear_flags(8'h00);
    $display("test refused start done");
    for (int k = 1; k < 5; k++) begin
      pulse(k);
      check(32'(status_flags[7 - k]), 32'h1);
    end
    clear_flags(8'h3f);
    check(32'(status_flags[6:3]), 32'h7);
    u_host.read_status(st);
    @(negedge clk_sys);
    check(32'(st), 32'(status_flags));
    @(posedge clk_sys);
    err_stop_armed <= 1'b1;
    pulse(2);
    check(32'(status_flags[ST_MOTOR_OFF]), 32'h1);
    u_host.write_byte(1'b1, CMD_START);
    check(acc_work, a + 32'h1);
    check(32'(status_flags[ST_MOTOR_OFF]), 32'h0);
    u_host.write_byte(1'b1, CMD_RESET);
    check(32'(status_flags[ST_MOTOR_OFF]), 32'h1);
    $display("test status flags done");
    give_verdict();
  end
endmodule
